// *** core/cob_pkg.sv ***
// constants for the object identifier dispatch block
package cob_pkg;
    localparam int ID_W        = 11;
    localparam int FUNC_MSB    = 10;
    localparam int FUNC_LSB    = 7;
    localparam int NODE_W      = 7;
    localparam logic [3:0] FC_NMT   = 4'h0;
    localparam logic [3:0] FC_SYNC  = 4'h1;
    localparam logic [3:0] FC_TPDO1 = 4'h3;
    localparam logic [3:0] FC_RPDO1 = 4'h4;
    localparam logic [3:0] FC_TPDO2 = 4'h5;
    localparam logic [3:0] FC_RPDO2 = 4'h6;
    localparam logic [3:0] FC_TPDO3 = 4'h7;
    localparam logic [3:0] FC_RPDO3 = 4'h8;
    localparam logic [3:0] FC_TPDO4 = 4'h9;
    localparam logic [3:0] FC_RPDO4 = 4'hA;
    localparam logic [3:0] FC_TSDO  = 4'hB;
    localparam logic [3:0] FC_RSDO  = 4'hC;
    localparam logic [3:0] FC_ERR   = 4'hE;
    localparam logic [7:0] NMT_RUN      = 8'h01;
    localparam logic [7:0] NMT_STOP     = 8'h02;
    localparam logic [7:0] NMT_PRERUN   = 8'h80;
    localparam logic [7:0] NMT_RST_NODE = 8'h81;
    localparam logic [7:0] NMT_RST_COMM = 8'h82;
    localparam logic [7:0] NODE_ALL     = 8'h00;
    localparam logic [6:0] NODE_RESET   = 7'h01;
    localparam logic [2:0] RATE_RESET   = 3'h6;
    typedef enum logic [3:0] {
        OBJ_NONE, OBJ_NMT, OBJ_SYNC, OBJ_RPDO1, OBJ_RPDO2, OBJ_RPDO3, OBJ_RPDO4, OBJ_RSDO,
        OBJ_ERRC
    } rx_obj_t;
    typedef enum logic [2:0] {
        TX_EMCY, TX_TPDO1, TX_TPDO2, TX_TPDO3, TX_TPDO4, TX_TSDO, TX_ERRC
    } tx_obj_t;
    typedef enum logic [1:0] {
        NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOPPED
    } nmt_state_t;
endpackage

// *** core/skid_buffer.sv ***
// two-entry buffer carrying transmit identifiers to the controller
`timescale 1ns/1ps
module skid_buffer #(
    parameter int WIDTH = 11
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic             wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [1:0]       cnt_reg, cnt_next;
    logic             push, pop;
    logic             in_ready_reg, in_ready_next;
    logic             out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;

    always_comb begin
        push      = in_valid && in_ready_reg;
        pop       = out_valid_reg && out_ready;
        mem_next  = mem_reg;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        if (push) begin
            mem_next[wptr_reg] = in_data;
            wptr_next          = ~wptr_reg;
        end
        if (pop) begin
            rptr_next = ~rptr_reg;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        in_ready_next  = (cnt_next != 2'h2);
        out_valid_next = (cnt_next != 2'h0);
        // head word registered so the port comes straight from a flop
        out_data_next  = mem_next[rptr_next];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg  <= 2'h0;
            in_ready_reg  <= 1'b1;
            out_valid_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
            in_ready_reg  <= in_ready_next;
            out_valid_reg <= out_valid_next;
        end
        mem_reg      <= mem_next;
        out_data_reg <= out_data_next;
    end

    assign in_ready  = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    a_no_overflow: assert property (@(posedge clk) disable iff (reset)
        cnt_reg == 2'h2 && !out_ready |=> cnt_reg == 2'h2 && out_data == $past(out_data))
        else $error("full buffer lost or changed its head word");
endmodule

// *** core/cob_dispatch.sv ***
// identifier compose and decode for the servo network slave interface
`timescale 1ns/1ps
// Overview of operation
// - every object travels as an 11-bit frame identifier setting priority and object
// - bits 10..7 hold function code, bits 6..0 hold the node address
// - only standard frames are accepted; extended frames are dropped
// - default identifiers are base per object plus node address; NMT and SYNC use node 0
// - identifiers readable via SDO; writes change only the base part
// - bit rate selectable among eight rates, default 1 Mbit/s
// - transmit PDOs sent on timer event or on received SYNC per configuration
// - NMT, SDO, PDO and SYNC services are handled
// - NMT first byte decoded: run, stop, pre-run, reset node, reset comm
// - NMT acted on when second byte is own node or zero
module cob_dispatch #(
    parameter int NUM_PDO = 4
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [6:0]            node_id,
    input  wire logic [2:0]            rate_sel,
    input  wire logic                  rx_valid,
    input  wire logic [10:0]           rx_id,
    input  wire logic                  rx_ext,
    input  wire logic [7:0]            rx_byte0,
    input  wire logic [7:0]            rx_byte1,
    output logic                       rx_hit,
    output cob_pkg::rx_obj_t           rx_obj,
    output logic [NUM_PDO-1:0]         rx_pdo_mask,
    output cob_pkg::nmt_state_t        nmt_state,
    output logic                       reset_node,
    output logic                       reset_comm,
    output logic [2:0]                 rate_act,
    input  wire logic                  cfg_wr,
    input  wire logic [3:0]            cfg_sel,
    input  wire logic [3:0]            cfg_func,
    output logic [10:0]                cfg_rd_id,
    input  wire logic [NUM_PDO-1:0]    tpdo_sync_mode,
    input  wire logic [NUM_PDO-1:0]    tpdo_timer_evt,
    input  wire logic                  tx_req,
    input  wire cob_pkg::tx_obj_t      tx_obj,
    output logic                       tx_ready,
    output logic                       tx_valid,
    input  wire logic                  tx_accept,
    output logic [10:0]                tx_id
);
    function automatic logic [10:0] make_id(input logic [3:0] fc, input logic [6:0] nd);
        make_id = {fc, nd};
    endfunction

    // per object function code table, index by rx/tx object, writable base part
    logic [3:0] fc_reg [16];
    logic [3:0] fc_next [16];
    logic [10:0] rd_reg, rd_next;
    cob_pkg::rx_obj_t rx_obj_reg, rx_obj_next;
    logic rx_hit_reg, rx_hit_next;
    logic [NUM_PDO-1:0] mask_reg, mask_next;
    cob_pkg::nmt_state_t st_reg, st_next;
    logic rn_reg, rn_next, rc_reg, rc_next;
    logic [2:0] rate_reg, rate_next;
    logic sync_seen;
    logic [NUM_PDO-1:0] pend_reg, pend_next;
    logic [1:0] pidx;
    logic buf_in_valid, buf_in_ready;
    logic [10:0] buf_in_data;
    logic [3:0] rfc;
    logic [6:0] rnd;
    logic own, pdo_ok, sdo_ok;

    always_comb begin
        rfc    = rx_id[cob_pkg::FUNC_MSB:cob_pkg::FUNC_LSB];
        rnd    = rx_id[cob_pkg::NODE_W-1:0];
        own    = (rnd == node_id);
        pdo_ok = (st_reg == cob_pkg::NMT_OPER);
        sdo_ok = (st_reg == cob_pkg::NMT_OPER) || (st_reg == cob_pkg::NMT_PREOP);
        rx_obj_next = cob_pkg::OBJ_NONE;
        if (rx_valid && !rx_ext) begin
            if (rx_id == make_id(fc_reg[0], 7'h00))
                rx_obj_next = cob_pkg::OBJ_NMT;
            else if (rx_id == make_id(fc_reg[1], 7'h00) && sdo_ok)
                rx_obj_next = cob_pkg::OBJ_SYNC;
            else if (own && rfc == fc_reg[2] && pdo_ok)
                rx_obj_next = cob_pkg::OBJ_RPDO1;
            else if (own && rfc == fc_reg[3] && pdo_ok)
                rx_obj_next = cob_pkg::OBJ_RPDO2;
            else if (own && rfc == fc_reg[4] && pdo_ok)
                rx_obj_next = cob_pkg::OBJ_RPDO3;
            else if (own && rfc == fc_reg[5] && pdo_ok)
                rx_obj_next = cob_pkg::OBJ_RPDO4;
            else if (own && rfc == fc_reg[6] && sdo_ok)
                rx_obj_next = cob_pkg::OBJ_RSDO;
            else if (own && rfc == fc_reg[7])
                rx_obj_next = cob_pkg::OBJ_ERRC;
        end
        rx_hit_next = (rx_obj_next != cob_pkg::OBJ_NONE);
        mask_next = '0;
        unique case (rx_obj_next)
            cob_pkg::OBJ_RPDO1: mask_next[0] = 1'b1;
            cob_pkg::OBJ_RPDO2: mask_next[1] = 1'b1;
            cob_pkg::OBJ_RPDO3: mask_next[2] = 1'b1;
            cob_pkg::OBJ_RPDO4: mask_next[3] = 1'b1;
            default: mask_next = '0;
        endcase
        sync_seen = (rx_obj_next == cob_pkg::OBJ_SYNC);
        // nmt command handling
        st_next = (st_reg == cob_pkg::NMT_INIT) ? cob_pkg::NMT_PREOP : st_reg;
        rn_next = 1'b0;
        rc_next = 1'b0;
        rate_next = rate_reg;
        if (rx_obj_next == cob_pkg::OBJ_NMT &&
            (rx_byte1 == {1'b0, node_id} || rx_byte1 == cob_pkg::NODE_ALL)) begin
            unique case (rx_byte0)
                cob_pkg::NMT_RUN:      st_next = cob_pkg::NMT_OPER;
                cob_pkg::NMT_STOP:     st_next = cob_pkg::NMT_STOPPED;
                cob_pkg::NMT_PRERUN:   st_next = cob_pkg::NMT_PREOP;
                cob_pkg::NMT_RST_NODE: begin
                    st_next = cob_pkg::NMT_INIT;
                    rn_next = 1'b1;
                end
                cob_pkg::NMT_RST_COMM: begin
                    st_next = cob_pkg::NMT_INIT;
                    rc_next = 1'b1;
                    rate_next = rate_sel;
                end
                default: st_next = st_reg;
            endcase
        end
        // sdo side writes base part only; node part own address, node 0 for entries 0 and 1
        fc_next = fc_reg;
        if (cfg_wr && cfg_sel > 4'h1)
            fc_next[cfg_sel] = cfg_func;
        rd_next = (cfg_sel < 4'h2) ? make_id(fc_reg[cfg_sel], 7'h00)
                                   : make_id(fc_reg[cfg_sel], node_id);
        // pdo trigger pending bits; a trigger landing while its bit is pushed sets it again
        pend_next = pend_reg;
        pidx = 2'h0;
        for (int i = NUM_PDO - 1; i >= 0; i--)
            if (pend_reg[i]) pidx = i[1:0];
        buf_in_valid = 1'b0;
        buf_in_data  = '0;
        if (tx_req && buf_in_ready) begin
            buf_in_valid = 1'b1;
            buf_in_data  = make_id(fc_reg[8 + int'(tx_obj)], node_id);
        end else if (|pend_reg) begin
            buf_in_valid = 1'b1;
            buf_in_data  = make_id(fc_reg[9 + int'(pidx)], node_id);
            if (buf_in_ready) pend_next[pidx] = 1'b0;
        end
        for (int i = 0; i < NUM_PDO; i++) begin
            if (pdo_ok && (tpdo_sync_mode[i] ? sync_seen : tpdo_timer_evt[i]))
                pend_next[i] = 1'b1;
        end
        if (!pdo_ok) pend_next = '0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fc_reg[0]  <= cob_pkg::FC_NMT;
            fc_reg[1]  <= cob_pkg::FC_SYNC;
            fc_reg[2]  <= cob_pkg::FC_RPDO1;
            fc_reg[3]  <= cob_pkg::FC_RPDO2;
            fc_reg[4]  <= cob_pkg::FC_RPDO3;
            fc_reg[5]  <= cob_pkg::FC_RPDO4;
            fc_reg[6]  <= cob_pkg::FC_RSDO;
            fc_reg[7]  <= cob_pkg::FC_ERR;
            fc_reg[8]  <= cob_pkg::FC_SYNC;
            fc_reg[9]  <= cob_pkg::FC_TPDO1;
            fc_reg[10] <= cob_pkg::FC_TPDO2;
            fc_reg[11] <= cob_pkg::FC_TPDO3;
            fc_reg[12] <= cob_pkg::FC_TPDO4;
            fc_reg[13] <= cob_pkg::FC_TSDO;
            fc_reg[14] <= cob_pkg::FC_ERR;
            fc_reg[15] <= cob_pkg::FC_NMT;
            rd_reg     <= '0;
            rx_obj_reg <= cob_pkg::OBJ_NONE;
            rx_hit_reg <= 1'b0;
            mask_reg   <= '0;
            st_reg     <= cob_pkg::NMT_INIT;
            rn_reg     <= 1'b0;
            rc_reg     <= 1'b0;
            rate_reg   <= cob_pkg::RATE_RESET;
            pend_reg   <= '0;
        end else begin
            fc_reg     <= fc_next;
            rd_reg     <= rd_next;
            rx_obj_reg <= rx_obj_next;
            rx_hit_reg <= rx_hit_next;
            mask_reg   <= mask_next;
            st_reg     <= st_next;
            rn_reg     <= rn_next;
            rc_reg     <= rc_next;
            rate_reg   <= rate_next;
            pend_reg   <= pend_next;
        end
    end

    skid_buffer #(.WIDTH(cob_pkg::ID_W)) u_txbuf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (tx_valid),
        .out_ready (tx_accept),
        .out_data  (tx_id)
    );

    assign tx_ready    = buf_in_ready;
    assign rx_hit      = rx_hit_reg;
    assign rx_obj      = rx_obj_reg;
    assign rx_pdo_mask = mask_reg;
    assign nmt_state   = st_reg;
    assign reset_node  = rn_reg;
    assign reset_comm  = rc_reg;
    assign rate_act    = rate_reg;
    assign cfg_rd_id   = rd_reg;

    a_ext_dropped: assert property (@(posedge clk) disable iff (reset)
        rx_valid && rx_ext |=> !rx_hit) else $error("extended frame was accepted");
    a_foreign_ignored: assert property (@(posedge clk) disable iff (reset)
        rx_valid && rx_id[10:7] != 4'h0 && rx_id[10:7] != 4'h1 && rx_id[6:0] != node_id
        |=> !rx_hit) else $error("foreign node frame was accepted");
    a_nmt_run: assert property (@(posedge clk) disable iff (reset)
        rx_valid && !rx_ext && rx_id == 11'h000 && rx_byte0 == 8'h01 && rx_byte1 == 8'h00
        |=> nmt_state == cob_pkg::NMT_OPER) else $error("broadcast run not taken");
    a_nmt_stop: assert property (@(posedge clk) disable iff (reset)
        rx_obj_next == cob_pkg::OBJ_NMT && rx_byte0 == 8'h02 && rx_byte1 == {1'b0, node_id}
        |=> nmt_state == cob_pkg::NMT_STOPPED) else $error("stop not taken");
    a_pdo_needs_run: assert property (@(posedge clk) disable iff (reset)
        |rx_pdo_mask |-> $past(st_reg) == cob_pkg::NMT_OPER) else $error("pdo outside run");
    a_rpdo1_id: assert property (@(posedge clk) disable iff (reset)
        rx_pdo_mask[0] |-> $past(rx_id) == 11'h200 + {4'h0, node_id} || $past(fc_reg[2]) != 4'h4)
        else $error("rpdo1 identifier wrong");
    a_rst_pulse: assert property (@(posedge clk) disable iff (reset)
        reset_comm |=> !reset_comm ##0 nmt_state == cob_pkg::NMT_PREOP)
        else $error("reset comm pulse wrong");
    a_node_field: assert property (@(posedge clk) disable iff (reset)
        tx_valid |-> tx_id[6:0] == node_id || $past(node_id) != node_id)
        else $error("tx node field wrong");
endmodule

// *** sim/net_master.sv ***
// network master model: issues received frames, consumes tagged identifiers
`timescale 1ns/1ps
module net_master (
    input  wire logic   clk,
    output logic        rx_valid,
    output logic [10:0] rx_id,
    output logic        rx_ext,
    output logic [7:0]  rx_byte0,
    output logic [7:0]  rx_byte1,
    output logic        tx_accept
);
    bit stall = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_id = 11'h7FF;
        rx_ext = 1'b0;
        rx_byte0 = 8'hFF;
        rx_byte1 = 8'hFF;
        tx_accept = 1'b1;
    end
    // caller sits at a falling edge; frame stands for one cycle
    task automatic send(input logic [10:0] id, input logic ext, input logic [7:0] b0, b1);
        rx_valid = 1'b1;
        rx_id = id;
        rx_ext = ext;
        rx_byte0 = b0;
        rx_byte1 = b1;
        @(negedge clk);
    endtask
    // released id and byte lines show the inverse so stale values never look valid
    task automatic idle();
        rx_valid = 1'b0;
        rx_id = ~rx_id;
        rx_byte0 = ~rx_byte0;
        rx_byte1 = ~rx_byte1;
        @(negedge clk);
    endtask
    always @(negedge clk) tx_accept <= stall ? 1'(($urandom % 4) == 0) : 1'b1;
endmodule

// *** sim/tb.sv ***
// self-checking bench for the identifier dispatch block
`timescale 1ns/1ps
module tb;
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    logic [6:0]          node_id = 7'h01;
    logic [2:0]          rate_sel = 3'h6;
    logic                rx_valid, rx_ext, rx_hit, reset_node, reset_comm;
    logic [10:0]         rx_id, cfg_rd_id, tx_id;
    logic [7:0]          rx_byte0, rx_byte1;
    cob_pkg::rx_obj_t    rx_obj;
    logic [3:0]          rx_pdo_mask, e;
    cob_pkg::nmt_state_t nmt_state;
    logic [2:0]          rate_act;
    logic                cfg_wr = 1'b0;
    logic                tx_req = 1'b0;
    logic [3:0]          cfg_sel = 4'h0;
    logic [3:0]          cfg_func = 4'h0;
    logic [3:0]          tpdo_sync_mode = 4'h0;
    logic [3:0]          tpdo_timer_evt = 4'h0;
    cob_pkg::tx_obj_t    tx_obj = cob_pkg::TX_EMCY;
    logic                tx_ready, tx_valid, tx_accept;
    int                  miscompares = 0;
    int                  total_checks = 0;
    logic [3:0]          rx_q[$];
    logic [10:0]         tx_q[$];
    logic [3:0]          fc[15] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE,
                                    4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hE};
    always #2.5 clk = ~clk;
    cob_dispatch uut (.clk, .reset, .node_id, .rate_sel, .rx_valid, .rx_id, .rx_ext,
        .rx_byte0, .rx_byte1, .rx_hit, .rx_obj, .rx_pdo_mask, .nmt_state, .reset_node,
        .reset_comm, .rate_act, .cfg_wr, .cfg_sel, .cfg_func, .cfg_rd_id, .tpdo_sync_mode,
        .tpdo_timer_evt, .tx_req, .tx_obj, .tx_ready, .tx_valid, .tx_accept, .tx_id);
    net_master m (.clk, .rx_valid, .rx_id, .rx_ext, .rx_byte0, .rx_byte1, .tx_accept);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [10:0] cid(input logic [3:0] f, input logic [6:0] n);
        return {f, n};
    endfunction
    // expected object 0 means the frame must be dropped
    task automatic frame(input logic [10:0] id, input logic ext, input logic [3:0] x);
        if (x != 4'h0) rx_q.push_back(x);
        m.send(id, ext, 8'($urandom), 8'($urandom));
        m.idle();
    endtask
    task automatic nmt(input logic [7:0] cmd, input logic [7:0] dst);
        m.send(11'h000, 1'b0, cmd, dst);
        m.idle();
    endtask
    task automatic drain();
        repeat (60) @(negedge clk);
        check("rx_left", 16'(rx_q.size()), 16'h0);
        check("tx_left", 16'(tx_q.size()), 16'h0);
    endtask
    always @(negedge clk) begin
        if (!reset && rx_hit === 1'b1 && rx_obj !== cob_pkg::OBJ_NMT) begin
            if (rx_q.size() == 0) begin
                check("rx_extra", 16'h1, 16'h0);
            end else begin
                e = rx_q.pop_front();
                check("rx_obj", rx_obj, e);
                check("mask", rx_pdo_mask, (e >= 3 && e <= 6) ? 16'(1 << (e - 3)) : 16'h0);
            end
        end
    end
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_accept === 1'b1) begin
            if (tx_q.size() == 0) check("tx_extra", 16'h1, 16'h0);
            else check("tx_id", tx_id, tx_q.pop_front());
        end
    end
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        void'($urandom(3));
        node_id = 7'(1 + $urandom % 63);
        rate_sel = 3'($urandom % 6);
        repeat (8) @(negedge clk);
        reset = 1'b0;
        check("rate", rate_act, 16'h6);
        @(negedge clk);
        check("state", nmt_state, cob_pkg::NMT_PREOP);
        frame(cid(4'hC, node_id), 1'b0, cob_pkg::OBJ_RSDO);
        frame(cid(4'h4, node_id), 1'b0, 4'h0);
        frame(11'h080, 1'b0, cob_pkg::OBJ_SYNC);
        $display("test preop done");
        nmt(8'h01, 8'(node_id % 63 + 1));
        check("state", nmt_state, cob_pkg::NMT_PREOP);
        nmt(8'h01, 8'(node_id));
        check("state", nmt_state, cob_pkg::NMT_OPER);
        nmt(8'h02, 8'(node_id));
        check("state", nmt_state, cob_pkg::NMT_STOPPED);
        frame(cid(4'hC, node_id), 1'b0, 4'h0);
        nmt(8'h80, 8'h00);
        check("state", nmt_state, cob_pkg::NMT_PREOP);
        nmt(8'h01, 8'h00);
        check("state", nmt_state, cob_pkg::NMT_OPER);
        nmt(8'h55, 8'h00);
        check("state", nmt_state, cob_pkg::NMT_OPER);
        $display("test nmt done");
        for (int k = 0; k < 4; k++) frame(cid(fc[2+k], node_id), 1'b0, 4'(3 + k));
        rx_q.push_back(cob_pkg::OBJ_RSDO);
        rx_q.push_back(cob_pkg::OBJ_SYNC);
        m.send(cid(4'hC, node_id), 1'b0, 8'h00, 8'h00);
        m.send(11'h080, 1'b0, 8'h00, 8'h00);
        m.idle();
        frame(cid(4'h4, node_id + 7'h1), 1'b0, 4'h0);
        frame(cid(4'h4, node_id), 1'b1, 4'h0);
        frame(cid(4'hD, node_id), 1'b0, 4'h0);
        frame(cid(4'hB, node_id), 1'b0, 4'h0);
        frame(cid(4'hE, node_id), 1'b0, cob_pkg::OBJ_ERRC);
        drain();
        $display("test receive done");
        for (int s = 0; s < 15; s++) begin
            cfg_sel = 4'(s);
            @(negedge clk);
            check("cfg_rd", cfg_rd_id, cid(fc[s], s < 2 ? 7'h0 : node_id));
        end
        cfg_wr = 1'b1;
        cfg_sel = 4'h1;
        cfg_func = 4'h5;
        @(negedge clk);
        cfg_sel = 4'h2;
        cfg_func = 4'hD;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_sel = 4'h1;
        @(negedge clk);
        check("cfg_ro", cfg_rd_id, 16'h080);
        cfg_sel = 4'h2;
        @(negedge clk);
        check("cfg_wr", cfg_rd_id, cid(4'hD, node_id));
        frame(cid(4'hD, node_id), 1'b0, cob_pkg::OBJ_RPDO1);
        frame(cid(4'h4, node_id), 1'b0, 4'h0);
        $display("test config done");
        m.stall = 1'b1;
        for (int k = 0; k < 7; k++) begin
            tx_q.push_back(cid(fc[8+k], node_id));
            tx_req = 1'b1;
            tx_obj = cob_pkg::tx_obj_t'(k);
            // ready moves only on a rising edge, so this value is what the next edge sees
            while (tx_ready !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
        tx_req = 1'b0;
        drain();
        m.stall = 1'b0;
        tpdo_sync_mode = 4'b0101;
        tx_q.push_back(cid(4'h3, node_id));
        tx_q.push_back(cid(4'h7, node_id));
        frame(11'h080, 1'b0, cob_pkg::OBJ_SYNC);
        drain();
        tx_q.push_back(cid(4'h5, node_id));
        tpdo_timer_evt = 4'b0010;
        @(negedge clk);
        tpdo_timer_evt = 4'h0;
        drain();
        $display("test transmit done");
        // reset pulses stand one cycle only: look before the bus goes idle
        m.send(11'h000, 1'b0, 8'h82, 8'h00);
        check("rst_comm", reset_comm, 16'h1);
        check("rate", rate_act, rate_sel);
        m.idle();
        check("rst_comm_end", reset_comm, 16'h0);
        check("state", nmt_state, cob_pkg::NMT_PREOP);
        m.send(11'h000, 1'b0, 8'h81, 8'(node_id));
        check("rst_node", reset_node, 16'h1);
        m.idle();
        drain();
        $display("test reset commands done");
        test_done();
    end
endmodule
